// File: verilog/atcd_timer.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`default_nettype none
module atcd_timer
   import atcd_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Crystal and pins
   input wire logic crystalInPin,
   output logic pinsDetached,
   output logic oscEnable,
   output logic compareOutPin,
   // Sleep and wake
   input wire logic sleeping,
   input wire logic [SLEEP_W-1:0] sleepMode,
   output logic wakeRequest,
   output logic cpuHalt,
   output logic irqDispatch,
   // Interrupt requests
   output logic compareIrqReq,
   output logic overflowIrqReq
);
   logic dpWrite;
   logic [DEC_W-1:0] dpAddr;
   logic aPhase;
   logic [DATA_W-1:0] wdata8;
   logic wrCount;
   logic wrCompare;
   logic wrControl;
   logic wrStatus;
   logic wrSpecial;
   logic wrFlags;
   logic wrIrqEn;
   logic [31:0] rdMux;

   logic xtalSync;
   logic xtalPrev;
   logic xtalRise;
   logic xtalRiseD;

   logic asyncClockSelect;
   logic asyncPrev;
   logic sourceSwap;

   logic [DATA_W-1:0] countValue;
   logic [DATA_W-1:0] compareValue;
   logic [DATA_W-1:0] timerControl;
   logic [DATA_W-1:0] countShadow;
   logic [DATA_W-1:0] tempVal [NUM_TEMP];
   logic pend [NUM_TEMP];
   logic edgeSeen [NUM_TEMP];
   logic commit [NUM_TEMP];
   logic wrAsync [NUM_TEMP];
   logic blockNext;

   logic [PRESC_W-1:0] presc;
   logic [PRESC_W-1:0] tapMask;
   logic prescalerClear;
   logic srcTick;
   logic timerTickEnable;
   logic [CTL_CS_W-1:0] clockSel;

   logic ovfEvt;
   logic cmpEvt;
   logic [FLAG_W-1:0] evt;
   logic [FLAG_W-1:0] evtHeld;
   logic [FLAG_W-1:0] evtRel;
   logic [FLAG_W-1:0] flagPipe [FLAG_SYNC_CYCLES];
   logic [FLAG_W-1:0] flagSet;
   logic [FLAG_W-1:0] flagClr;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] irqEn;

   logic wakeArm;
   logic wakeFire;
   logic [HALT_W-1:0] haltCnt;

   // Bus: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign aPhase = hsel & htrans[1] & hready;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dpWrite <= 1'b0;
         dpAddr <= '0;
      end else begin
         dpWrite <= aPhase & hwrite & (hsize == HSIZE_WORD);
         dpAddr <= haddr[DEC_W-1:0];
      end
   end

   assign wdata8 = hwdata[DATA_W-1:0];
   assign wrCount = dpWrite && (dpAddr == OFF_COUNT);
   assign wrCompare = dpWrite && (dpAddr == OFF_COMPARE);
   assign wrControl = dpWrite && (dpAddr == OFF_CONTROL);
   assign wrStatus = dpWrite && (dpAddr == OFF_STATUS);
   assign wrSpecial = dpWrite && (dpAddr == OFF_SPECIAL);
   assign wrFlags = dpWrite && (dpAddr == OFF_FLAGS);
   assign wrIrqEn = dpWrite && (dpAddr == OFF_IRQ_EN);

   always_comb begin
      rdMux = '0;
      unique case (haddr[DEC_W-1:0])
         OFF_COUNT: rdMux[DATA_W-1:0] = asyncClockSelect ? countShadow : countValue;
         OFF_COMPARE: rdMux[DATA_W-1:0] = compareValue;
         OFF_CONTROL: rdMux[DATA_W-1:0] = timerControl;
         OFF_STATUS: begin
            rdMux[ST_ASYNC] = asyncClockSelect;
            rdMux[ST_CNT_PEND] = pend[IDX_COUNT];
            rdMux[ST_CMP_PEND] = pend[IDX_COMPARE];
            rdMux[ST_CTL_PEND] = pend[IDX_CONTROL];
         end
         OFF_FLAGS: rdMux[FLAG_W-1:0] = flags;
         OFF_IRQ_EN: rdMux[FLAG_W-1:0] = irqEn;
         default: rdMux = '0;
      endcase
   end

   // Read data sampled in the address phase, shown in the data phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (aPhase && !hwrite) begin
         hrdata <= rdMux;
      end
   end

   // Crystal pin seen as an edge enable, never used as a clock
   atcd_sync #(
      .STAGES(SYNC_STAGES)
   ) uXtalSync (
      .clk(clk),
      .rst_n(rst_n),
      .d(crystalInPin),
      .q(xtalSync)
   );

   // Edge detection needs clk above four crystal periods to see every edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xtalPrev <= 1'b0;
         xtalRiseD <= 1'b0;
      end else begin
         xtalPrev <= xtalSync;
         xtalRiseD <= xtalRise;
      end
   end

   assign xtalRise = xtalSync & ~xtalPrev;

   // Clock source select
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         asyncClockSelect <= 1'b0;
         asyncPrev <= 1'b0;
      end else begin
         if (wrStatus) begin
            asyncClockSelect <= hwdata[ST_ASYNC];
         end
         asyncPrev <= asyncClockSelect;
      end
   end

   assign sourceSwap = asyncClockSelect != asyncPrev;
   assign pinsDetached = asyncClockSelect;
   assign srcTick = asyncClockSelect ? xtalRise : 1'b1;

   // Oscillator runs only with async select, and then stops only in power-down and standby
   assign oscEnable = asyncClockSelect &
      !(sleeping && ((sleepMode == SLP_POWER_DOWN) || (sleepMode == SLP_STANDBY)));

   // Per-register temporary holding and commit
   assign wrAsync[IDX_COUNT] = wrCount & asyncClockSelect;
   assign wrAsync[IDX_COMPARE] = wrCompare & asyncClockSelect;
   assign wrAsync[IDX_CONTROL] = wrControl & asyncClockSelect;

   for (genvar i = 0; i < NUM_TEMP; i++) begin : gTemp
      // A new write restarts the edge count; software should wait first
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            tempVal[i] <= RST_REG;
            pend[i] <= 1'b0;
            edgeSeen[i] <= 1'b0;
         end else if (sourceSwap) begin
            pend[i] <= 1'b0;
            edgeSeen[i] <= 1'b0;
         end else if (wrAsync[i]) begin
            tempVal[i] <= wdata8;
            pend[i] <= 1'b1;
            edgeSeen[i] <= 1'b0;
         end else if (pend[i] && xtalRise) begin
            if (edgeSeen[i]) begin
               pend[i] <= 1'b0;
            end
            edgeSeen[i] <= ~edgeSeen[i];
         end
      end
      assign commit[i] = pend[i] & xtalRise & edgeSeen[i];
   end

   // Counter: the tick is only an enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         countValue <= RST_REG;
      end else if (commit[IDX_COUNT]) begin
         countValue <= tempVal[IDX_COUNT];
      end else if (wrCount && !asyncClockSelect) begin
         countValue <= wdata8;
      end else if (timerTickEnable) begin
         countValue <= countValue + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         compareValue <= RST_REG;
      end else if (commit[IDX_COMPARE]) begin
         compareValue <= tempVal[IDX_COMPARE];
      end else if (wrCompare && !asyncClockSelect) begin
         compareValue <= wdata8;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerControl <= RST_REG;
      end else if (commit[IDX_CONTROL]) begin
         timerControl <= tempVal[IDX_CONTROL];
      end else if (wrControl && !asyncClockSelect) begin
         timerControl <= wdata8;
      end
   end

   // A count load blocks the match on the following tick
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blockNext <= 1'b0;
      end else if (commit[IDX_COUNT] || (wrCount && !asyncClockSelect)) begin
         blockNext <= 1'b1;
      end else if (timerTickEnable) begin
         blockNext <= 1'b0;
      end
   end

   // Shadow refreshed the cycle after each crystal edge, once the count settled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         countShadow <= RST_REG;
      end else if (xtalRiseD) begin
         countShadow <= countValue;
      end
   end

   // Prescaler
   assign prescalerClear = wrSpecial & hwdata[SFR_PSC_CLR];

   always_ff @(posedge clk) begin
      if (!rst_n || prescalerClear) begin
         presc <= '0;
      end else if (srcTick) begin
         presc <= presc + 10'h001;
      end
   end

   assign clockSel = timerControl[CTL_CS_LSB +: CTL_CS_W];

   always_comb begin
      unique case (clockSel)
         CS_STOP: tapMask = MASK_DIV1;
         CS_DIV1: tapMask = MASK_DIV1;
         CS_DIV8: tapMask = MASK_DIV8;
         CS_DIV32: tapMask = MASK_DIV32;
         CS_DIV64: tapMask = MASK_DIV64;
         CS_DIV128: tapMask = MASK_DIV128;
         CS_DIV256: tapMask = MASK_DIV256;
         CS_DIV1024: tapMask = MASK_DIV1024;
      endcase
   end

   assign timerTickEnable = srcTick && (clockSel != CS_STOP) &&
      ((presc & tapMask) == tapMask);

   // Events
   assign ovfEvt = timerTickEnable && (countValue == COUNT_MAX);
   assign cmpEvt = timerTickEnable && (countValue == compareValue) &&
      !pend[IDX_COMPARE] && !pend[IDX_COUNT] && !blockNext;
   assign evt = {cmpEvt, ovfEvt};

   // Output pin follows the tick directly
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         compareOutPin <= 1'b0;
      end else if (cmpEvt && timerControl[CTL_OUT_EN]) begin
         compareOutPin <= ~compareOutPin;
      end
   end

   // Async events wait one timer cycle, then three processor cycles
   // Cleared in sync mode so no stale event leaks out after a switch
   always_ff @(posedge clk) begin
      if (!rst_n || !asyncClockSelect) begin
         evtHeld <= '0;
      end else if (xtalRise) begin
         evtHeld <= evt;
      end
   end

   assign evtRel = xtalRise ? evtHeld : '0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int k = 0; k < FLAG_SYNC_CYCLES; k++) begin
            flagPipe[k] <= '0;
         end
      end else begin
         flagPipe[0] <= evtRel;
         for (int k = 1; k < FLAG_SYNC_CYCLES; k++) begin
            flagPipe[k] <= flagPipe[k-1];
         end
      end
   end

   assign flagSet = asyncClockSelect ? flagPipe[FLAG_SYNC_CYCLES-1] : evt;
   assign flagClr = wrFlags ? hwdata[FLAG_W-1:0] : '0;

   // Write one to clear; a set in the same cycle wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~flagClr) | flagSet;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqEn <= '0;
      end else if (wrIrqEn) begin
         irqEn <= hwdata[FLAG_W-1:0];
      end
   end

   assign compareIrqReq = flags[FLG_CMP] & irqEn[FLG_CMP];
   assign overflowIrqReq = flags[FLG_OVF] & irqEn[FLG_OVF];

   // Wake starts on the next timer cycle after the condition
   assign wakeFire = sleeping && (compareIrqReq || overflowIrqReq) && wakeArm &&
      srcTick;

   // Rearm needs one more timer cycle after a wake
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeArm <= 1'b1;
      end else if (wakeFire) begin
         wakeArm <= 1'b0;
      end else if (!wakeArm && srcTick) begin
         wakeArm <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeRequest <= 1'b0;
         irqDispatch <= 1'b0;
         haltCnt <= '0;
      end else begin
         wakeRequest <= wakeFire;
         irqDispatch <= haltCnt == HALT_LAST;
         if (wakeFire) begin
            haltCnt <= HALT_CYCLES;
         end else if (haltCnt != '0) begin
            haltCnt <= haltCnt - 3'h1;
         end
      end
   end

   assign cpuHalt = haltCnt != '0;
endmodule : atcd_timer
`default_nettype wire

// File: verilog/atcd_pkg.sv
// Behaviour
// - Timer is fully synchronous; selected tick is a clock enable, never a clock.
// - I/O clock by default; async select takes crystal pin, detaches both pins.
// - Switching clock source may corrupt count, compare and control contents.
// - Async writes go to a temporary register, committed after two crystal edges.
// - Count, compare and control each own a separate temporary register.
// - A status register shows each pending temporary transfer.
// - Compare match suppressed while compare or count write is pending.
// - Interrupt logic needs one timer clock cycle to rearm after a wake-up.
// - In async mode oscillator runs in all sleeps except power-down, standby.
// - Wake-up starts on the timer clock cycle after the interrupt condition.
// - After wake-up the processor halts four cycles, then runs the handler.
// - In async mode count reads come from a shadow refreshed on each rising crystal edge.
// - Async flag synchronisation takes three processor cycles plus one timer cycle.
// - Compare output pin changes on the timer tick, not resynchronised.
// - Prescaler offers divide by 1, 8, 32, 64, 128, 256, 1024 and stop.
// - Writing one to prescaler clear resets the prescaler phase.
// - Pending flag set on async write, cleared when destination is loaded.
// - Clock select zero stops the timer; others rise in division order.
`default_nettype none
package atcd_pkg;
   localparam int DATA_W = 8;
   localparam int DEC_W = 8;
   localparam int NUM_TEMP = 3;
   localparam int PRESC_W = 10;
   localparam int FLAG_W = 2;
   localparam int SLEEP_W = 3;
   localparam int HALT_W = 3;

   // Register byte offsets
   localparam logic [DEC_W-1:0] OFF_COUNT = 8'h00;
   localparam logic [DEC_W-1:0] OFF_COMPARE = 8'h04;
   localparam logic [DEC_W-1:0] OFF_CONTROL = 8'h08;
   localparam logic [DEC_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [DEC_W-1:0] OFF_SPECIAL = 8'h10;
   localparam logic [DEC_W-1:0] OFF_FLAGS = 8'h14;
   localparam logic [DEC_W-1:0] OFF_IRQ_EN = 8'h18;

   // Temporary register indices
   localparam int IDX_COUNT = 0;
   localparam int IDX_COMPARE = 1;
   localparam int IDX_CONTROL = 2;

   // Field positions
   localparam int ST_ASYNC = 3;
   localparam int ST_CNT_PEND = 2;
   localparam int ST_CMP_PEND = 1;
   localparam int ST_CTL_PEND = 0;
   localparam int CTL_CS_LSB = 0;
   localparam int CTL_CS_W = 3;
   localparam int CTL_OUT_EN = 3;
   localparam int SFR_PSC_CLR = 0;
   localparam int FLG_OVF = 0;
   localparam int FLG_CMP = 1;

   // Reset values
   localparam logic [DATA_W-1:0] RST_REG = 8'h00;

   // Clock select codes, increasing division
   localparam logic [CTL_CS_W-1:0] CS_STOP = 3'h0;
   localparam logic [CTL_CS_W-1:0] CS_DIV1 = 3'h1;
   localparam logic [CTL_CS_W-1:0] CS_DIV8 = 3'h2;
   localparam logic [CTL_CS_W-1:0] CS_DIV32 = 3'h3;
   localparam logic [CTL_CS_W-1:0] CS_DIV64 = 3'h4;
   localparam logic [CTL_CS_W-1:0] CS_DIV128 = 3'h5;
   localparam logic [CTL_CS_W-1:0] CS_DIV256 = 3'h6;
   localparam logic [CTL_CS_W-1:0] CS_DIV1024 = 3'h7;

   // Prescaler tap masks
   localparam logic [PRESC_W-1:0] MASK_DIV1 = 10'h000;
   localparam logic [PRESC_W-1:0] MASK_DIV8 = 10'h007;
   localparam logic [PRESC_W-1:0] MASK_DIV32 = 10'h01f;
   localparam logic [PRESC_W-1:0] MASK_DIV64 = 10'h03f;
   localparam logic [PRESC_W-1:0] MASK_DIV128 = 10'h07f;
   localparam logic [PRESC_W-1:0] MASK_DIV256 = 10'h0ff;
   localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3ff;

   localparam logic [DATA_W-1:0] COUNT_MAX = 8'hff;

   // Timing in edges and cycles
   localparam int FLAG_SYNC_CYCLES = 3;
   localparam logic [HALT_W-1:0] HALT_CYCLES = 3'h4;
   localparam logic [HALT_W-1:0] HALT_LAST = 3'h1;

   // Sleep mode codes
   localparam logic [SLEEP_W-1:0] SLP_POWER_DOWN = 3'h2;
   localparam logic [SLEEP_W-1:0] SLP_STANDBY = 3'h6;

   // AHB-Lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : atcd_pkg
`default_nettype wire

// File: verilog/atcd_sync.sv
`default_nettype none
module atcd_sync #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in and out
   input wire logic d,
   output logic q
);
   logic [STAGES-1:0] chain;

   // Only the last stage is read outside
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], d};
      end
   end

   assign q = chain[STAGES-1];
endmodule : atcd_sync
`default_nettype wire

// File: tb/atcd_xtal_model.sv
`default_nettype none
module atcd_xtal_model #(
   parameter int HALF = 21
) (
   // Oscillator control
   input wire logic run,
   // Crystal level
   output logic xtal
);
   timeunit 1ns;
   timeprecision 1ps;
   // 42 ns period keeps the main clock above four times the crystal rate
   // Phase is unrelated to clk; a stopped oscillator rests low
   // Starts already settled, standing in for the long start-up wait
   initial begin
      xtal = 1'b0;
      forever begin
         #HALF;
         xtal = (run === 1'b1) ? !xtal : 1'b0;
      end
   end
endmodule : atcd_xtal_model
`default_nettype wire

// File: tb/atcd_timer_assertions.sv
`default_nettype none
module atcd_timer_assertions
   import atcd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Pins and sleep
   input wire logic pinsDetached,
   input wire logic oscEnable,
   input wire logic sleeping,
   input wire logic [SLEEP_W-1:0] sleepMode,
   input wire logic wakeRequest,
   input wire logic cpuHalt,
   input wire logic irqDispatch
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dpWr;
   logic dpRd;
   logic [7:0] dpAddr;
   logic deepSleep;
   // Address phase captured so the data phase is judged on its own edge
   always_ff @(posedge clk) begin
      dpWr <= rst_n && hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD;
      dpRd <= rst_n && hsel && htrans[1] && hready && !hwrite;
      dpAddr <= haddr[7:0];
   end
   assign deepSleep = sleeping && (sleepMode == SLP_POWER_DOWN || sleepMode == SLP_STANDBY);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_osc_sleep: assert property (oscEnable == (pinsDetached && !deepSleep))
      else $error("oscillator enable wrong");
   a_async_detach: assert property (dpWr && dpAddr == OFF_STATUS |=>
      pinsDetached == $past(hwdata[ST_ASYNC])) else $error("pins detach wrong");
   a_status_mirror: assert property (dpRd && dpAddr == OFF_STATUS |->
      hrdata[ST_ASYNC] == pinsDetached) else $error("status async bit wrong");
   a_upper_zero: assert property (dpRd |-> hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_clear_reads0: assert property (dpRd && dpAddr == OFF_SPECIAL |-> hrdata == 32'h0)
      else $error("prescaler clear reads nonzero");
   a_wake_halt: assert property ($rose(wakeRequest) |-> ##[0:1] cpuHalt)
      else $error("no halt after wake");
   a_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
      else $error("wake not a pulse");
   a_halt_four: assert property ($rose(cpuHalt) |-> cpuHalt[*4] ##1 !cpuHalt)
      else $error("halt not four cycles");
   a_dispatch_end: assert property ($fell(cpuHalt) |-> irqDispatch)
      else $error("no dispatch at halt end");
   a_dispatch_only: assert property (irqDispatch |-> !cpuHalt && $past(cpuHalt))
      else $error("dispatch outside halt end");
endmodule : atcd_timer_assertions
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb
   import atcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, xtal, pinsDetached, oscEnable;
   logic compareOutPin, sleeping, wakeRequest, cpuHalt, irqDispatch;
   logic compareIrqReq, overflowIrqReq;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans;
   logic [2:0] hsize, sz;
   logic [SLEEP_W-1:0] sleepMode;
   logic [7:0] c0;
   int errors, comparisons, cycles, n, m, w;
   int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   atcd_timer dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crystalInPin(xtal),
      .pinsDetached(pinsDetached), .oscEnable(oscEnable), .compareOutPin(compareOutPin),
      .sleeping(sleeping), .sleepMode(sleepMode), .wakeRequest(wakeRequest),
      .cpuHalt(cpuHalt), .irqDispatch(irqDispatch), .compareIrqReq(compareIrqReq),
      .overflowIrqReq(overflowIrqReq));
   atcd_xtal_model xosc (.run(oscEnable), .xtal(xtal));
   always #2 clk = ~clk;
   task automatic end_sim;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   // Long enough for the slowest prescaler tap plus the async phases
   always @(posedge clk) begin
      cycles++;
      if (cycles > 40000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic rng(input string nm, input int lo, input int hi, input logic [7:0] v);
      comparisons++;
      if ((v >= lo && v <= hi) !== 1'b1) begin
         errors++;
         $display("[FAIL] %s exp %0d..%0d got %h", nm, lo, hi, v);
      end
   endtask : rng
   // One single transfer; called just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : xfer
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask : rchk
   // Poll status until the given pending bits clear, bounded
   task automatic waitst(input logic [3:0] mk);
      int i;
      i = 0;
      do begin
         xfer(1'b0, OFF_STATUS, 32'h0);
         i++;
      end while ((rdat[3:0] & mk) != 4'h0 && i < 200);
      chk("pending", 32'h0, {28'h0, rdat[3:0] & mk});
   endtask : waitst
   initial begin
      clk = 0; rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
      sz = HSIZE_WORD; hsize = HSIZE_WORD; sleeping = 0; sleepMode = 3'h3;
      errors = 0; comparisons = 0; cycles = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 32; a += 4) begin
         rchk("reset reg", 8'(a), 32'h0);
      end
      chk("detach reset", 0, pinsDetached);
      chk("okay resp", 0, hresp);
      sz = 3'h0;
      xfer(1'b1, OFF_COUNT, 32'h5a);
      sz = HSIZE_WORD;
      rchk("byte write", OFF_COUNT, 32'h0);
      xfer(1'b1, OFF_COUNT, 32'h5a);
      repeat (20) @(posedge clk);
      rchk("stopped count", OFF_COUNT, 32'h5a);
      for (int c = 1; c < 8; c++) begin
         xfer(1'b1, OFF_COUNT, 32'h0);
         xfer(1'b1, OFF_SPECIAL, 32'h1);
         xfer(1'b1, OFF_CONTROL, 32'(c));
         repeat (divs[c] * 8) @(posedge clk);
         xfer(1'b1, OFF_CONTROL, 32'h0);
         xfer(1'b0, OFF_COUNT, 32'h0);
         rng("tap count", 7, 11, rdat[7:0]);
      end
      xfer(1'b1, OFF_COMPARE, 32'h80);
      xfer(1'b1, OFF_COUNT, 32'h08);
      xfer(1'b1, OFF_IRQ_EN, 32'h3);
      xfer(1'b1, OFF_CONTROL, 32'h9);
      repeat (300) @(posedge clk);
      xfer(1'b1, OFF_CONTROL, 32'h0);
      rchk("flags", OFF_FLAGS, 32'h3);
      chk("cmp pin", 1, compareOutPin);
      chk("irq reqs", 3, {compareIrqReq, overflowIrqReq});
      xfer(1'b1, OFF_FLAGS, 32'h3);
      rchk("flags clr", OFF_FLAGS, 32'h0);
      xfer(1'b1, OFF_IRQ_EN, 32'h0);
      xfer(1'b1, OFF_STATUS, 32'h8);
      @(posedge clk);
      chk("detach", 1, pinsDetached);
      chk("osc on", 1, oscEnable);
      xfer(1'b1, OFF_COMPARE, 32'h33);
      xfer(1'b1, OFF_COUNT, 32'h40);
      rchk("pending", OFF_STATUS, 32'he);
      waitst(4'h7);
      rchk("cmp commit", OFF_COMPARE, 32'h33);
      rchk("shadow", OFF_COUNT, 32'h40);
      xfer(1'b1, OFF_CONTROL, 32'h1);
      waitst(4'h1);
      xfer(1'b1, OFF_FLAGS, 32'h3);
      xfer(1'b1, OFF_IRQ_EN, 32'h3);
      xfer(1'b0, OFF_COUNT, 32'h0);
      c0 = rdat[7:0];
      repeat (60) @(posedge clk);
      xfer(1'b0, OFF_COUNT, 32'h0);
      rng("async step", 4, 7, rdat[7:0] - c0);
      sleeping <= 1'b1;
      sleepMode <= SLP_POWER_DOWN;
      @(posedge clk);
      chk("osc pd", 0, oscEnable);
      sleepMode <= SLP_STANDBY;
      @(posedge clk);
      chk("osc sb", 0, oscEnable);
      sleepMode <= 3'h3;
      sleeping <= 1'b0;
      @(posedge clk);
      chk("osc ps", 1, oscEnable);
      xfer(1'b1, OFF_COUNT, 32'hfc);
      waitst(4'h4);
      n = 0;
      while (overflowIrqReq !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk("ovf req", 1, overflowIrqReq);
      sleeping <= 1'b1;
      n = 0; m = 0; w = 0;
      repeat (200) begin
         @(posedge clk);
         if (wakeRequest === 1'b1) begin
            sleeping <= 1'b0;
            w++;
         end
         n += (cpuHalt === 1'b1);
         m += (irqDispatch === 1'b1);
      end
      chk("wakes", 1, w);
      chk("halt cycles", 4, n);
      chk("dispatch", 1, m);
      end_sim();
   end
endmodule : tb
bind atcd_timer atcd_timer_assertions u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .pinsDetached(pinsDetached), .oscEnable(oscEnable),
   .sleeping(sleeping), .sleepMode(sleepMode), .wakeRequest(wakeRequest),
   .cpuHalt(cpuHalt), .irqDispatch(irqDispatch));
`default_nettype wire
